// [test/rlt_core_model.sv]
// link core stand-in: echoes bench status requests, negotiates rates
// assumes req_i is driven synchronously to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module rlt_core_model import rlt_pkg::*; (
  input  wire logic           clk_sys_i,
  input  wire logic           nrst_i,
  input  wire rlt_core_ctrl_t ctrl_i,
  input  wire rlt_core_stat_t req_i,
  output var rlt_core_stat_t  stat_o,
  output var int              n_force_o
);
  rlt_core_stat_t stat_next;

  // status follows requests; rate tracks the enabled maximum
  always_comb begin
    stat_next = req_i;
    stat_next.rate_mode = ctrl_i.max_rate;
    if (ctrl_i.force_startup_idle) begin
      stat_next.link_startup_state = 3'h0;
    end
  end

  // one cycle of latency, count the standby pulses
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_o <= '0;
      n_force_o <= 0;
    end else begin
      stat_o <= stat_next;
      if (ctrl_i.force_startup_idle) begin
        n_force_o <= n_force_o + 1;
      end
    end
  end
endmodule
`default_nettype wire

// [test/rlt_regs_tb.sv]
// bench of the link template register bank: apb master, core model
// assumes only the design package and the core model file
`timescale 1ns/1ps
`default_nettype none
module rlt_regs_tb;
  import rlt_pkg::*;
  logic clk, nrst, psel, pen, pwr, pre, pse, irq, e;
  logic [15:0] pa;
  logic [31:0] pwd, prd, r;
  rlt_core_ctrl_t cc;
  rlt_core_stat_t cs, req;
  rlt_stream_in_t [NUM_CH-1:0] st;
  logic [NUM_CH-1:0][7:0] txw;
  logic [7:0] w [6], ex [4], rx [4];
  logic [63:0] rv;
  int n_fail, total_checks, nf0;
  const logic [11:0] ci [6] = '{12'h800, 12'h801, 12'h802, 12'h803, 12'h804, 12'h80c};
  const logic [7:0] cm [6] = '{8'h13, 8'h03, 8'h3f, 8'h3f, 8'h01, 8'h83};
  int nf;

  rlt_regs DUT (.clk_sys_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(pre), .pslverr_o(pse),
    .core_ctrl_o(cc), .core_stat_i(cs), .strm_i(st), .tx_word_o(txw), .irq_o(irq));
  rlt_core_model MDL (.clk_sys_i(clk), .nrst_i(nrst), .ctrl_i(cc), .req_i(req), .stat_o(cs), .n_force_o(nf));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ************
  // helpers
  // ************
  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    total_checks++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk) {psel, pen, pwr, pa, pwd} <= {2'b10, wr, 2'b00, i, 2'b00, 24'h0, d};
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (pre !== 1'b1 && ++n < 50);
    chk(pre, 1'b1);
    r = prd;
    e = pse;
    {psel, pen} <= 2'b00;
    @(posedge clk);
  endtask
  function automatic logic [7:0] nxt(input bit p, input logic [7:0] v);
    return p ? {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]} : v + 8'h01;
  endfunction
  function automatic logic [1:0] rate(input logic [1:0] s);
    return (s == 2'h3) ? 2'h2 : s;
  endfunction
  function automatic logic [7:0] sx(input int k, input rlt_core_stat_t s, input logic [1:0] rt);
    case (k)
      0: return {s.rx_frame_lost, s.rx_signal_lost, s.version_mismatch, s.processor_irq, s.eth_fifo_flags};
      1: return {6'h0, rt};
      2: return {s.rx_frame_lost, s.rx_signal_lost, s.version_mismatch, s.remote_l1_bits};
      3: return s.remote_protocol_version;
      4: return {2'h0, s.remote_fast_cm_pointer};
      5: return {1'b0, s.remote_slow_cm_rate, 1'b0, s.slow_cm_rate};
      default: return {5'h0, s.link_startup_state};
    endcase
  endfunction
  task automatic strobe(input int c, input bit tx, input logic [7:0] d);
    @(posedge clk) st[c] <= {tx, !tx, d};
    @(posedge clk) st[c] <= '0;
    @(posedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end

  // ************
  // main sequence
  // ************
  initial begin
    {nrst, psel, pen, pwr, pa, pwd, req, st} = '0;
    nf0 = $urandom(87);
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      apb(0, ci[k], 0);
      chk(r, 0);
      w[k] = 8'($urandom);
      apb(1, ci[k], w[k]);
      apb(0, ci[k], 0);
      chk(r, w[k] & cm[k]);
    end
    chk({cc.tx_sap_defect_ind, cc.tx_remote_alarm_ind}, w[1][1:0]);
    chk({cc.tx_frame_number_clear_en, cc.tx_hyperframe_clear_en, cc.slow_cm_rate_en}, w[2][5:0]);
    chk(cc.tx_fast_cm_pointer, w[3][5:0]);
    chk(cc.tx_reset_req_or_ack, w[4][0]);
    chk({cc.core_reset, cc.short_timing_select, cc.controller_role_select}, {w[5][7], w[5][1:0]});
    for (int s = 0; s < 4; s++) begin
      apb(1, IDX_CTRL_RATE, 8'(s));
      chk(cc.max_rate, rate(2'(s)));
    end
    apb(1, IDX_CTRL_RATE, 8'h00);
    nf0 = nf;
    apb(1, IDX_CTRL_RATE, 8'h13);
    apb(1, IDX_CTRL_RATE, 8'h13);
    chk(nf - nf0, 1);
    repeat (3) begin
      rv = {$urandom, $urandom};
      req <= rv[$bits(req)-1:0];
      repeat (3) @(posedge clk);
      for (int k = 0; k < 7; k++) begin
        apb(0, IDX_ERR_FLAGS + 12'(k), 0);
        chk(r, sx(k, req, 2'h3 & rate(2'h3)));
      end
    end
    apb(1, IDX_ERR_FLAGS, 8'hff);
    apb(0, IDX_ERR_FLAGS, 0);
    chk(r, sx(0, req, 2'h2));
    apb(0, 12'h0f00, 0);
    chk({e, r}, 33'h1_0000_0000);
    {req.rx_frame_lost, req.rx_signal_lost} <= 2'b00;
    repeat (3) @(posedge clk);
    apb(0, IDX_IRQ_STAT, 0);
    apb(1, IDX_IRQ_MASK, 8'h01);
    {req.rx_frame_lost, req.rx_signal_lost} <= 2'b11;
    repeat (4) @(posedge clk);
    chk(irq, 1'b1);
    apb(0, IDX_IRQ_STAT, 0);
    chk(r, 32'h0000_0003);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    for (int c = 0; c < NUM_CH; c++) begin
      ex[c] = PAT_SEED;
      rx[c] = PAT_SEED;
      repeat (3) begin
        strobe(c, 1, 0);
        ex[c] = nxt(c == 0 || c == 3, ex[c]);
        chk(txw[c], ex[c]);
      end
    end
    for (int c = 0; c < NUM_CH; c++) begin
      for (int j = 0; j < NUM_CH; j++) begin
        strobe(j, 0, rx[j] ^ ((j == c) ? 8'h40 : 8'h00));
        rx[j] = nxt(j == 0 || j == 3, rx[j]);
      end
      apb(0, IDX_LOOP_ERR, 0);
      chk(r, 32'h1 << c);
    end
    final_report();
  end
endmodule
`default_nettype wire

// [verilog/rlt_pattern_unit.sv]
// one pattern generator and checker of the sample application.
// assumes tx_take and rx_valid are one-cycle strobes in the clk_sys_i domain.
`timescale 1ns/1ps
`default_nettype none
module rlt_pattern_unit import rlt_pkg::*; #(
  parameter bit PRBS = 1'b1
) (
  input  wire logic     clk_sys_i,
  input  wire logic     nrst_i,
  input  wire rlt_stream_in_t strm_i,
  output logic [7:0]    tx_word_o,
  output logic          err_o
);

  rlt_pat_state_t st_reg;
  rlt_pat_state_t st_next;

  // ****************************************
  // generator and checker
  // ****************************************
  // generator advances per taken word, checker per received word
  always_comb begin
    st_next = st_reg;
    if (strm_i.tx_take) begin
      st_next.gen = rlt_next_word(PRBS, st_reg.gen);
    end
    if (strm_i.rx_valid) begin
      st_next.err         = (strm_i.rx_word != st_reg.expect_word);
      st_next.expect_word = rlt_next_word(PRBS, st_reg.expect_word);
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '{gen: PAT_SEED, expect_word: PAT_SEED, err: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign tx_word_o = st_reg.gen;
  assign err_o     = st_reg.err;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  a_check_mismatch_flag: assert property (strm_i.rx_valid |=> err_o == ($past(strm_i.rx_word) != $past(st_reg.expect_word))) else $error("checker flag wrong");
  a_check_flag_holds: assert property (!strm_i.rx_valid |=> $stable(err_o)) else $error("checker flag moved without data");
  a_gen_steps_on_take: assert property (strm_i.tx_take |=> tx_word_o == rlt_next_word(PRBS, $past(tx_word_o))) else $error("generator did not step");

endmodule
`default_nettype wire

// [verilog/rlt_pkg.sv]
// package of the link template register bank: register indices, field
// positions, reset values, pattern constants and the carrier structs.
// assumes a 32-bit apb master and a link core with plain control/status ports.
package rlt_pkg;

  // ****************************************
  // register map (word index, byte address = 4 * index)
  // ****************************************
  localparam int unsigned RLT_AW = 16;
  localparam logic [11:0] IDX_CTRL_RATE    = 12'h0800;
  localparam logic [11:0] IDX_CTRL_IND     = 12'h0801;
  localparam logic [11:0] IDX_CTRL_EN      = 12'h0802;
  localparam logic [11:0] IDX_CTRL_PTR     = 12'h0803;
  localparam logic [11:0] IDX_CTRL_RST     = 12'h0804;
  localparam logic [11:0] IDX_ERR_FLAGS    = 12'h0805;
  localparam logic [11:0] IDX_RATE_STAT    = 12'h0806;
  localparam logic [11:0] IDX_L1_STAT      = 12'h0807;
  localparam logic [11:0] IDX_VERSION      = 12'h0808;
  localparam logic [11:0] IDX_PTR_STAT     = 12'h0809;
  localparam logic [11:0] IDX_HDLC_STAT    = 12'h080a;
  localparam logic [11:0] IDX_STARTUP_STAT = 12'h080b;
  localparam logic [11:0] IDX_TEST_CTRL    = 12'h080c;
  localparam logic [11:0] IDX_LOOP_ERR     = 12'h080d;
  localparam logic [11:0] IDX_IRQ_STAT     = 12'h0820;
  localparam logic [11:0] IDX_IRQ_MASK     = 12'h0821;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] MASK_RATE     = 8'h13;
  localparam logic [7:0] MASK_IND      = 8'h03;
  localparam logic [7:0] MASK_EN       = 8'h3f;
  localparam logic [7:0] MASK_PTR      = 8'h3f;
  localparam logic [7:0] MASK_RST      = 8'h01;
  localparam logic [7:0] MASK_TEST     = 8'h83;
  localparam logic [3:0] MASK_IRQ      = 4'h0f;
  localparam int unsigned FORCE_BIT    = 4;
  localparam int unsigned CORE_RST_BIT = 7;
  localparam int unsigned SHORT_BIT    = 1;
  localparam int unsigned ROLE_BIT     = 0;
  localparam logic [1:0] RATE_614      = 2'h0;
  localparam logic [1:0] RATE_1228     = 2'h1;
  localparam logic [1:0] RATE_2457     = 2'h2;
  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned IRQ_FRAME    = 0;
  localparam int unsigned IRQ_SIGNAL   = 1;
  localparam int unsigned IRQ_VERSION  = 2;
  localparam int unsigned IRQ_CHECK    = 3;

  // ****************************************
  // pattern channels
  // ****************************************
  localparam int unsigned NUM_CH    = 4;
  localparam int unsigned CH_FAST   = 0;
  localparam int unsigned CH_SAMPLE = 1;
  localparam int unsigned CH_VENDOR = 2;
  localparam int unsigned CH_SLOW   = 3;
  localparam logic [7:0] PAT_SEED   = 8'h01;
  localparam logic [7:0] PAT_STEP   = 8'h01;

  typedef struct packed {
    logic [1:0] max_rate;
    logic       force_startup_idle;
    logic       tx_sap_defect_ind;
    logic       tx_remote_alarm_ind;
    logic       tx_frame_number_clear_en;
    logic       tx_hyperframe_clear_en;
    logic [3:0] slow_cm_rate_en;
    logic [5:0] tx_fast_cm_pointer;
    logic       tx_reset_req_or_ack;
    logic       core_reset;
    logic       short_timing_select;
    logic       controller_role_select;
  } rlt_core_ctrl_t;

  typedef struct packed {
    logic       rx_frame_lost;
    logic       rx_signal_lost;
    logic       version_mismatch;
    logic       processor_irq;
    logic [3:0] eth_fifo_flags;
    logic [1:0] rate_mode;
    logic [4:0] remote_l1_bits;
    logic [7:0] remote_protocol_version;
    logic [5:0] remote_fast_cm_pointer;
    logic [2:0] remote_slow_cm_rate;
    logic [2:0] slow_cm_rate;
    logic [2:0] link_startup_state;
  } rlt_core_stat_t;

  typedef struct packed {
    logic       tx_take;
    logic       rx_valid;
    logic [7:0] rx_word;
  } rlt_stream_in_t;

  typedef struct packed {
    logic [7:0] gen;
    logic [7:0] expect_word;
    logic       err;
  } rlt_pat_state_t;

  typedef struct packed {
    logic [7:0]       ctrl_rate;
    logic [7:0]       ctrl_ind;
    logic [7:0]       ctrl_en;
    logic [7:0]       ctrl_ptr;
    logic [7:0]       ctrl_rst;
    logic [7:0]       test_ctrl;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] ev_prev;
    rlt_core_ctrl_t   core;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             irq;
  } rlt_state_t;

  // next word of a pattern: prbs (x^8+x^6+x^5+x^4+1) or counter
  function automatic logic [7:0] rlt_next_word(input logic prbs, input logic [7:0] w);
    return prbs ? {w[6:0], w[7] ^ w[5] ^ w[4] ^ w[3]} : 8'(w + PAT_STEP);
  endfunction

  // maximum rate code: both upper codes select the top rate
  function automatic logic [1:0] rlt_rate_code(input logic [1:0] sel);
    return (sel == RATE_614) ? RATE_614 : ((sel == RATE_1228) ? RATE_1228 : RATE_2457);
  endfunction

endpackage

// [verilog/rlt_regs.sv]
// link template register bank: apb slave, control ports to the link core,
// status sampling, pattern channels and an interrupt.
// assumes a 40 MHz clk_sys_i, status inputs synchronous to it, apb on the same clock.
//
// Contract
// - rate field 00/01/1x selects 614.4, 1228.8, 2457.6 MHz maximum line rate.
// - writing force bit zero to one forces startup machine into standby.
// - control register 1 bits 1:0 drive transmitted defect and alarm indications.
// - control register 2 bits 5:0 enable frame, hyperframe resets and HDLC rates.
// - control register 3 bits 5:0 supply transmitted Ethernet channel pointer.
// - control register 4 bit 0 drives reset request or acknowledge.
// - error register shows frame, signal, version, interrupt and FIFO flags.
// - status register 0 bits 1:0 show the negotiated line rate.
// - status register 1 shows loss flags and received Z.130.0 bits.
// - version register shows the received protocol version byte.
// - status register 2 bits 5:0 show received Ethernet pointer.
// - status register 3 shows received HDLC rate 6:4, negotiated 2:0.
// - test control bit 7 resets the link core.
// - test bit 1 selects short timing, bit 0 selects controller role.
// - loopback error bits 3:0 flag HDLC, vendor, IQ, Ethernet mismatches.
// - pseudo-random patterns generated and checked on both C&M channels.
// - numbered words generated and checked on IQ and vendor channels.
// - all software storage lives here, driving and sampling core ports.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rlt_regs import rlt_pkg::*; (
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [RLT_AW-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // link core
  output rlt_core_ctrl_t         core_ctrl_o,
  input  wire rlt_core_stat_t    core_stat_i,
  // pattern channels
  input  wire rlt_stream_in_t [NUM_CH-1:0] strm_i,
  output logic [NUM_CH-1:0][7:0] tx_word_o,
  // interrupt
  output logic                   irq_o
);

  rlt_state_t        st_reg;
  rlt_state_t        st_next;
  logic [NUM_CH-1:0] chk_err;
  logic [11:0]       idx;
  logic              addr_ok;
  logic              setup;
  logic              done;
  logic              wr_done;
  logic              rd_done;
  logic [IRQ_W-1:0]  ev_now;
  logic [IRQ_W-1:0]  ev_rise;

  // ****************************************
  // pattern generators and checkers
  // ****************************************
  // prbs on the control channels, counters on sample and vendor channels
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    rlt_pattern_unit #(
      .PRBS((c == CH_FAST) || (c == CH_SLOW))
    ) u_pat (
      .clk_sys_i(clk_sys_i),
      .nrst_i   (nrst_i),
      .strm_i   (strm_i[c]),
      .tx_word_o(tx_word_o[c]),
      .err_o    (chk_err[c])
    );
  end

  // ****************************************
  // bus decode
  // ****************************************
  // word-aligned index; upper address bits must be zero
  assign idx     = paddr_i[13:2];
  assign addr_ok = (paddr_i[1:0] == 2'h0) && (paddr_i[RLT_AW-1:14] == 2'h0);
  assign setup   = psel_i && !penable_i;
  assign done    = psel_i && penable_i && st_reg.pready;
  assign wr_done = done && pwrite_i && addr_ok;
  assign rd_done = done && !pwrite_i && addr_ok;

  // events that raise interrupt status bits
  assign ev_now  = {|chk_err, core_stat_i.version_mismatch, core_stat_i.rx_signal_lost,
                    core_stat_i.rx_frame_lost};
  assign ev_rise = ev_now & ~st_reg.ev_prev;

  // read data for an index; unknown index reads zero
  function automatic logic [8:0] read_mux(input logic [11:0] i, input rlt_state_t s,
                                          input rlt_core_stat_t cs, input logic [NUM_CH-1:0] ce);
    logic [7:0] d;
    logic       hit;
    d   = 8'h00;
    hit = 1'b1;
    unique case (i)
      IDX_CTRL_RATE:    d = s.ctrl_rate;
      IDX_CTRL_IND:     d = s.ctrl_ind;
      IDX_CTRL_EN:      d = s.ctrl_en;
      IDX_CTRL_PTR:     d = s.ctrl_ptr;
      IDX_CTRL_RST:     d = s.ctrl_rst;
      IDX_ERR_FLAGS:    d = {cs.rx_frame_lost, cs.rx_signal_lost, cs.version_mismatch,
                             cs.processor_irq, cs.eth_fifo_flags};
      IDX_RATE_STAT:    d = {6'h00, cs.rate_mode};
      IDX_L1_STAT:      d = {cs.rx_frame_lost, cs.rx_signal_lost, cs.version_mismatch,
                             cs.remote_l1_bits};
      IDX_VERSION:      d = cs.remote_protocol_version;
      IDX_PTR_STAT:     d = {2'h0, cs.remote_fast_cm_pointer};
      IDX_HDLC_STAT:    d = {1'b0, cs.remote_slow_cm_rate, 1'b0, cs.slow_cm_rate};
      IDX_STARTUP_STAT: d = {5'h00, cs.link_startup_state};
      IDX_TEST_CTRL:    d = s.test_ctrl;
      IDX_LOOP_ERR:     d = {4'h0, ce[CH_SLOW], ce[CH_VENDOR], ce[CH_SAMPLE], ce[CH_FAST]};
      IDX_IRQ_STAT:     d = {4'h0, s.irq_stat};
      IDX_IRQ_MASK:     d = {4'h0, s.irq_mask};
      default:          hit = 1'b0;
    endcase
    return {hit, d};
  endfunction

  // ****************************************
  // register next state
  // ****************************************
  always_comb begin
    logic [8:0] rd;
    rd      = read_mux(idx, st_reg, core_stat_i, chk_err);
    st_next = st_reg;

    // apb: answer one cycle after setup, data captured at setup
    st_next.pready  = setup;
    st_next.pslverr = setup && !(addr_ok && rd[8]);
    st_next.prdata  = (setup && addr_ok && !pwrite_i) ? {24'h00_0000, rd[7:0]} : 32'h0000_0000;

    // writes land only on control registers; status writes are dropped
    if (wr_done) begin
      unique case (idx)
        IDX_CTRL_RATE: st_next.ctrl_rate = pwdata_i[7:0] & MASK_RATE;
        IDX_CTRL_IND:  st_next.ctrl_ind  = pwdata_i[7:0] & MASK_IND;
        IDX_CTRL_EN:   st_next.ctrl_en   = pwdata_i[7:0] & MASK_EN;
        IDX_CTRL_PTR:  st_next.ctrl_ptr  = pwdata_i[7:0] & MASK_PTR;
        IDX_CTRL_RST:  st_next.ctrl_rst  = pwdata_i[7:0] & MASK_RST;
        IDX_TEST_CTRL: st_next.test_ctrl = pwdata_i[7:0] & MASK_TEST;
        IDX_IRQ_MASK:  st_next.irq_mask  = pwdata_i[IRQ_W-1:0] & MASK_IRQ;
        default:       st_next.irq_mask  = st_reg.irq_mask;
      endcase
    end

    // sticky status: read clears, a new event in the same cycle wins
    if (rd_done && (idx == IDX_IRQ_STAT)) begin
      st_next.irq_stat = st_reg.irq_stat & ~st_reg.prdata[IRQ_W-1:0]; // only bits the read returned
    end
    st_next.irq_stat = st_next.irq_stat | ev_rise;
    st_next.ev_prev  = ev_now;
    st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);

    // core control ports follow the stored fields
    st_next.core.max_rate                 = rlt_rate_code(st_next.ctrl_rate[1:0]);
    st_next.core.force_startup_idle       = st_next.ctrl_rate[FORCE_BIT]
                                            && !st_reg.ctrl_rate[FORCE_BIT];
    st_next.core.tx_sap_defect_ind        = st_next.ctrl_ind[1];
    st_next.core.tx_remote_alarm_ind      = st_next.ctrl_ind[0];
    st_next.core.tx_frame_number_clear_en = st_next.ctrl_en[5];
    st_next.core.tx_hyperframe_clear_en   = st_next.ctrl_en[4];
    st_next.core.slow_cm_rate_en          = st_next.ctrl_en[3:0];
    st_next.core.tx_fast_cm_pointer       = st_next.ctrl_ptr[5:0];
    st_next.core.tx_reset_req_or_ack      = st_next.ctrl_rst[0];
    st_next.core.core_reset               = st_next.test_ctrl[CORE_RST_BIT];
    st_next.core.short_timing_select      = st_next.test_ctrl[SHORT_BIT];
    st_next.core.controller_role_select   = st_next.test_ctrl[ROLE_BIT];
  end

  // state register, holding every field software can write; checker flags are stored in the pattern units
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '{ctrl_rate: CTRL_RESET, ctrl_ind: CTRL_RESET, ctrl_en: CTRL_RESET,
                  ctrl_ptr: CTRL_RESET, ctrl_rst: CTRL_RESET, test_ctrl: CTRL_RESET,
                  irq_mask: '0, irq_stat: '0, ev_prev: '0, core: '0,
                  prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0, irq: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign prdata_o    = st_reg.prdata;
  assign pready_o    = st_reg.pready;
  assign pslverr_o   = st_reg.pslverr;
  assign core_ctrl_o = st_reg.core;
  assign irq_o       = st_reg.irq;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  property p_field_write(logic [11:0] i);
    wr_done && (idx == i) ##1 1'b1;
  endproperty

  a_rate_decode: assert property (core_ctrl_o.max_rate == rlt_rate_code(st_reg.ctrl_rate[1:0])
    && core_ctrl_o.max_rate != 2'h3) else $error("rate code wrong");
  a_force_edge_pulse: assert property (wr_done && idx == IDX_CTRL_RATE && pwdata_i[FORCE_BIT]
    && !st_reg.ctrl_rate[FORCE_BIT] |=> core_ctrl_o.force_startup_idle ##1
    !core_ctrl_o.force_startup_idle) else $error("standby force not a single pulse");
  a_force_no_level: assert property (core_ctrl_o.force_startup_idle |->
    $past(!st_reg.ctrl_rate[FORCE_BIT])) else $error("standby force without rising bit");
  a_ind_write: assert property (wr_done && idx == IDX_CTRL_IND |=>
    {core_ctrl_o.tx_sap_defect_ind, core_ctrl_o.tx_remote_alarm_ind} == $past(pwdata_i[1:0]))
    else $error("indications not driven");
  a_enable_write: assert property (wr_done && idx == IDX_CTRL_EN |=>
    {core_ctrl_o.tx_frame_number_clear_en, core_ctrl_o.tx_hyperframe_clear_en,
     core_ctrl_o.slow_cm_rate_en} == $past(pwdata_i[5:0])) else $error("enables not driven");
  a_pointer_write: assert property (wr_done && idx == IDX_CTRL_PTR |=>
    core_ctrl_o.tx_fast_cm_pointer == $past(pwdata_i[5:0])) else $error("pointer not driven");
  a_reset_signal: assert property (core_ctrl_o.tx_reset_req_or_ack == st_reg.ctrl_rst[0]
    && core_ctrl_o.core_reset == st_reg.test_ctrl[CORE_RST_BIT]) else $error("reset outputs wrong");
  a_role_timing: assert property (wr_done && idx == IDX_TEST_CTRL |=>
    core_ctrl_o.controller_role_select == $past(pwdata_i[ROLE_BIT])
    && core_ctrl_o.short_timing_select == $past(pwdata_i[SHORT_BIT])) else $error("test bits wrong");
  a_l1_status_read: assert property (setup && !pwrite_i && addr_ok && idx == IDX_L1_STAT |=>
    prdata_o == {24'h00_0000, $past(core_stat_i.rx_frame_lost), $past(core_stat_i.rx_signal_lost),
    $past(core_stat_i.version_mismatch), $past(core_stat_i.remote_l1_bits)})
    else $error("status 1 read wrong");
  a_version_read: assert property (setup && !pwrite_i && addr_ok && idx == IDX_VERSION |=>
    prdata_o[7:0] == $past(core_stat_i.remote_protocol_version)) else $error("version read wrong");
  a_loop_err_read: assert property (setup && !pwrite_i && addr_ok && idx == IDX_LOOP_ERR |=>
    prdata_o[3:0] == {$past(chk_err[CH_SLOW]), $past(chk_err[CH_VENDOR]),
    $past(chk_err[CH_SAMPLE]), $past(chk_err[CH_FAST])}) else $error("loopback read wrong");
  a_unmapped_zero: assert property (setup && !(addr_ok && read_mux(idx, st_reg, core_stat_i,
    chk_err) >= 9'h100) |=> pslverr_o && prdata_o == 32'h0000_0000) else $error("unmapped answer wrong");
  a_status_write_ignored: assert property (wr_done && (idx == IDX_VERSION || idx == IDX_ERR_FLAGS)
    |=> $stable(st_reg.ctrl_rate)
    && $stable(st_reg.test_ctrl)) else $error("status write had effect");
  a_irq_level: assert property (irq_o == |(st_reg.irq_stat & st_reg.irq_mask))
    else $error("interrupt level wrong");
  a_ready_one_cycle: assert property (setup |=> pready_o ##1 !pready_o || (psel_i && !penable_i))
    else $error("ready timing wrong");

  c_force_write: cover property (p_field_write(IDX_CTRL_RATE));
  c_l1_read: cover property (rd_done && idx == IDX_L1_STAT);
  c_irq_raise: cover property (!irq_o ##1 irq_o);
  c_check_error: cover property (|chk_err);
  c_unmapped: cover property (done && pslverr_o);

endmodule
`default_nettype wire
